// *** hdl/cmr_consts.svh ***
// Offsets, field positions, reset values and decode constants of the bank.
// Assumes inclusion by bare name from design files.
`ifndef CMR_CONSTS_SVH
`define CMR_CONSTS_SVH
`define CMR_OFS_COMP 8'hD0
`define CMR_OFS_VOUT 8'hD1
`define CMR_OFS_OPS 8'hD2
`define CMR_OFS_ADDR 8'hD3
`define CMR_RST_COMP 8'h09
`define CMR_RST_VOUT 8'h40
`define CMR_RST_OPS 8'h05
`define CMR_RST_ADDR 8'hB0
`define CMR_OPS_MASK 8'h07
`define CMR_COMP_CFF_BIT 4
`define CMR_COMP_RAMP_LSB 1
`define CMR_COMP_FLT_BIT 0
`define CMR_VOUT_DIS_BIT 6
`define CMR_VOUT_PGD_LSB 2
`define CMR_VOUT_RNG_LSB 0
`define CMR_OPS_FSW_LSB 1
`define CMR_OPS_LL_BIT 0
`define CMR_ADDR_EN_BIT 7
`define CMR_PGD_ZERO 4'hF
`define CMR_CYC_PER_MS 15'h4E20
`endif

// *** hdl/cmr_pkg.sv ***
// Types shared by the configuration bank files.
// Assumes cmr_consts.svh is on the include path.
package cmr_pkg;
  typedef struct packed {
    logic cff_50pf;
    logic [2:0] ramp_code;
    logic [3:0] ramp_index;
    logic follower_fault_en;
    logic output_discharge_sel;
    logic [3:0] power_good_delay;
    logic [4:0] power_good_delay_ms;
    logic [1:0] output_divider_range;
    logic [3:0] divider_shift;
    logic [1:0] fsw_sel;
    logic [10:0] fsw_khz;
    logic light_load_mode_sel;
    logic [6:0] bus_address;
  } cmr_ctrl_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } cmr_req_t;
endpackage

// *** hdl/cmr_power_good_delay.sv ***
// Power-good delay timer: counts whole milliseconds of ref_clk cycles.
// Assumes a 20 MHz ref_clk and a clean start pulse from the same domain.
`timescale 1ns/1ps
`include "cmr_consts.svh"
module cmr_power_good_delay #(
  parameter int CYC_PER_MS = `CMR_CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [4:0] delay_ms,
  output logic done
);
  logic [14:0] cyc;
  logic [4:0] ms;
  logic run;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run <= 1'b0;
      cyc <= 15'h0000;
      ms <= 5'h00;
      done <= 1'b0;
    end else if (start) begin
      cyc <= 15'h0000;
      ms <= 5'h00;
      run <= (delay_ms != 5'h00);
      done <= (delay_ms == 5'h00);
    end else if (run) begin
      if (cyc == 15'(CYC_PER_MS - 1)) begin
        cyc <= 15'h0000;
        ms <= ms + 5'h01;
        if (ms + 5'h01 == delay_ms) begin
          run <= 1'b0;
          done <= 1'b1;
        end
      end else begin
        cyc <= cyc + 15'h0001;
      end
    end
  end
endmodule

// *** hdl/cmr_cfg_regs.sv ***
// Manufacturer configuration bank: four 8-bit command registers.
// Assumes a bus engine delivers decoded one-cycle write/read strobes.
//
// Function
// - Cff bit picks 20pF or 50pF.
// - Single-phase ramp codes decode to millivolts.
// - Multi-phase ramp codes use second table.
// - Bit 0 enables follower fault detection.
// - Bit 6 selects discharge at enable low.
// - Power-good delay 1-15 ms, 1111 zero.
// - Range field sets divider ratio.
// - Range code sets output voltage span.
// - Frequency field selects 400 to 1000 kHz.
// - Bit 0 picks light-load mode; upper reserved.
// - Address from register or strap pin.
// - Address register resets to 0xB0.
`timescale 1ns/1ps
`include "cmr_consts.svh"
module cmr_cfg_regs #(
  parameter int CYC_PER_MS = `CMR_CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input cmr_pkg::cmr_req_t req,
  input wire logic phase_mode_bit,
  input wire logic [6:0] addr_strap,
  input wire logic ctrl_enable,
  input wire logic power_good_pin,
  input wire logic output_ok,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic cmd_hit,
  output cmr_pkg::cmr_ctrl_t ctrl,
  output logic [9:0] ramp_uv10,
  output logic [12:0] vout_min_mv,
  output logic [12:0] vout_max_mv,
  output logic discharge_on,
  output logic follower_fault,
  output logic power_good_out
);
  import cmr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] comp;
  logic [7:0] vout;
  logic [7:0] ops;
  logic [7:0] addr;
  logic [2:0] en_s;
  logic [2:0] pg_s;
  logic [6:0] strap_s1;
  logic [6:0] strap_s2;
  logic [6:0] strap_s3;
  logic [6:0] strap_q;
  logic en_lvl;
  logic pg_lvl;
  logic ok_q;
  logic pg_done;
  logic hit;

  assign hit = (req.cmd == `CMR_OFS_COMP) || (req.cmd == `CMR_OFS_VOUT) ||
               (req.cmd == `CMR_OFS_OPS) || (req.cmd == `CMR_OFS_ADDR);
  assign cmd_hit = hit;

  ////////////////////////////////////////////////////////////////////////
  // live write path
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      comp <= `CMR_RST_COMP;
      vout <= `CMR_RST_VOUT;
      ops <= `CMR_RST_OPS;
      addr <= `CMR_RST_ADDR;
    end else if (req.wr) begin
      case (req.cmd)
        `CMR_OFS_COMP: comp <= req.wdata;
        `CMR_OFS_VOUT: vout <= req.wdata;
        `CMR_OFS_OPS: ops <= req.wdata & `CMR_OPS_MASK;
        `CMR_OFS_ADDR: addr <= req.wdata;
        default: comp <= comp;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        case (req.cmd)
          `CMR_OFS_COMP: rdata <= comp;
          `CMR_OFS_VOUT: rdata <= vout;
          `CMR_OFS_OPS: rdata <= ops;
          `CMR_OFS_ADDR: rdata <= addr;
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin inputs pass three flops; a change counts once stages two and three
  // agree.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_s <= 3'h0;
      pg_s <= 3'h0;
      en_lvl <= 1'b0;
      pg_lvl <= 1'b0;
      strap_s1 <= 7'h00;
      strap_s2 <= 7'h00;
      strap_s3 <= 7'h00;
      strap_q <= 7'h00;
    end else begin
      en_s <= {en_s[1:0], ctrl_enable};
      pg_s <= {pg_s[1:0], power_good_pin};
      if (en_s[1] == en_s[2]) begin
        en_lvl <= en_s[2];
      end
      if (pg_s[1] == pg_s[2]) begin
        pg_lvl <= pg_s[2];
      end
      strap_s1 <= addr_strap;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      // A strap word is taken only once two stages agree on every bit.
      if (strap_s2 == strap_s3) begin
        strap_q <= strap_s3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    ctrl = '0;
    ctrl.cff_50pf = comp[`CMR_COMP_CFF_BIT];
    ctrl.ramp_code = comp[`CMR_COMP_RAMP_LSB +: 3];
    ctrl.ramp_index = {phase_mode_bit, comp[`CMR_COMP_RAMP_LSB +: 3]};
    ctrl.follower_fault_en = comp[`CMR_COMP_FLT_BIT];
    ctrl.output_discharge_sel = vout[`CMR_VOUT_DIS_BIT];
    ctrl.power_good_delay = vout[`CMR_VOUT_PGD_LSB +: 4];
    if (ctrl.power_good_delay == `CMR_PGD_ZERO) begin
      ctrl.power_good_delay_ms = 5'd0;
    end else begin
      ctrl.power_good_delay_ms = {1'b0, ctrl.power_good_delay} + 5'd1;
    end
    ctrl.output_divider_range = vout[`CMR_VOUT_RNG_LSB +: 2];
    ctrl.divider_shift = {2'b00, ctrl.output_divider_range};
    ctrl.fsw_sel = ops[`CMR_OPS_FSW_LSB +: 2];
    case (ctrl.fsw_sel)
      2'b00: ctrl.fsw_khz = 11'd400;
      2'b01: ctrl.fsw_khz = 11'd600;
      2'b10: ctrl.fsw_khz = 11'd800;
      default: ctrl.fsw_khz = 11'd1000;
    endcase
    ctrl.light_load_mode_sel = ops[`CMR_OPS_LL_BIT];
    if (addr[`CMR_ADDR_EN_BIT]) begin
      ctrl.bus_address = addr[6:0];
    end else begin
      ctrl.bus_address = strap_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ramp table, single-phase codes then multi-phase codes, in 0.1 mV
  always_comb begin
    case (ctrl.ramp_index)
      4'h0: ramp_uv10 = 10'd56;
      4'h1: ramp_uv10 = 10'd98;
      4'h2: ramp_uv10 = 10'd180;
      4'h3: ramp_uv10 = 10'd300;
      4'h4: ramp_uv10 = 10'd85;
      4'h5: ramp_uv10 = 10'd151;
      4'h6: ramp_uv10 = 10'd270;
      4'h7: ramp_uv10 = 10'd440;
      4'h8: ramp_uv10 = 10'd86;
      4'h9: ramp_uv10 = 10'd150;
      4'hA: ramp_uv10 = 10'd270;
      4'hB: ramp_uv10 = 10'd450;
      4'hC: ramp_uv10 = 10'd130;
      4'hD: ramp_uv10 = 10'd230;
      4'hE: ramp_uv10 = 10'd410;
      default: ramp_uv10 = 10'd680;
    endcase
  end

  always_comb begin
    case (ctrl.output_divider_range)
      2'b00: vout_min_mv = 13'd400;
      2'b01: vout_min_mv = 13'd400;
      2'b10: vout_min_mv = 13'd700;
      default: vout_min_mv = 13'd1300;
    endcase
    vout_max_mv = 13'd672 << ctrl.divider_shift;
  end

  ////////////////////////////////////////////////////////////////////////
  // discharge when enable low, bit value 1
  assign discharge_on = ctrl.output_discharge_sel && !en_lvl;
  assign follower_fault = ctrl.follower_fault_en && !pg_lvl && en_lvl;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ok_q <= 1'b0;
    end else begin
      ok_q <= output_ok && en_lvl;
    end
  end

  cmr_power_good_delay #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_pgd (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(output_ok && en_lvl && !ok_q),
    .delay_ms(ctrl.power_good_delay_ms),
    .done(pg_done)
  );

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_good_out <= 1'b0;
    end else begin
      power_good_out <= pg_done && ok_q && output_ok && en_lvl;
    end
  end
endmodule

// *** dv/cmr_cfg_regs_sva.sv ***
// Checker for the configuration bank, bound to cmr_cfg_regs.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module cmr_cfg_regs_sva (
  input wire logic ref_clk,
  input wire logic arst_n,
  input cmr_pkg::cmr_req_t req,
  input wire logic phase_mode_bit,
  input wire logic [6:0] addr_strap,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic cmd_hit,
  input cmr_pkg::cmr_ctrl_t ctrl,
  input wire logic [9:0] ramp_uv10,
  input wire logic [12:0] vout_max_mv
);
  import cmr_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_rv; rvalid == $past(req.rd); endproperty
  a_rv: assert property (p_rv) else $error("read answer late");
  property p_hit; cmd_hit == (req.cmd[7:2] == 6'h34); endproperty
  a_hit: assert property (p_hit) else $error("command decode");
  property p_rsv; req.rd && req.cmd == 8'hD2 |=> rdata[7:3] == 5'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_cff; req.wr && req.cmd == 8'hD0 |=>
    ctrl.cff_50pf == $past(req.wdata[4]); endproperty
  a_cff: assert property (p_cff) else $error("cff");
  property p_r1; !phase_mode_bit && ctrl.ramp_code == 3'h0 |->
    ramp_uv10 == 10'h038; endproperty
  a_r1: assert property (p_r1) else $error("single ramp");
  property p_r3; phase_mode_bit && ctrl.ramp_code == 3'h7 |->
    ramp_uv10 == 10'h2A8; endproperty
  a_r3: assert property (p_r3) else $error("multi ramp");
  property p_pgd; ctrl.power_good_delay_ms == (ctrl.power_good_delay ==
    4'hF ? 5'h00 : 5'(ctrl.power_good_delay + 4'h1)); endproperty
  a_pgd: assert property (p_pgd) else $error("power_good_delay");
  property p_rng; vout_max_mv == (13'h02A0 << ctrl.output_divider_range);
  endproperty
  a_rng: assert property (p_rng) else $error("range");
  property p_fsw; ctrl.fsw_khz == 11'h190 + 11'h0C8 * ctrl.fsw_sel;
  endproperty
  a_fsw: assert property (p_fsw) else $error("fsw");
  property p_adr; req.wr && req.cmd == 8'hD3 |=> ctrl.bus_address ==
    ($past(req.wdata[7]) ? $past(req.wdata[6:0]) : addr_strap); endproperty
  a_adr: assert property (p_adr) else $error("address");
  c_wr: cover property (req.wr);
  c_rd: cover property (rvalid && rdata == 8'hB0);
  c_mp: cover property (phase_mode_bit && ctrl.ramp_code == 3'h7);
endmodule
bind cmr_cfg_regs cmr_cfg_regs_sva sva_u (.ref_clk, .arst_n, .req,
  .phase_mode_bit, .addr_strap, .rdata, .rvalid, .cmd_hit, .ctrl, .ramp_uv10,
  .vout_max_mv);

// *** dv/cmr_host_model.sv ***
// Host model: issues single-byte register commands to the bank.
// Assumes a free-running ref_clk; requests launched at falling edges.
`timescale 1ns/1ps
module cmr_host_model (
  input wire logic ref_clk,
  output cmr_pkg::cmr_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  import cmr_pkg::*;
  initial req = '0;
  task automatic xfer(input logic w, input logic [7:0] c, d,
                      output logic [7:0] q);
    @(negedge ref_clk);
    req = '{wr: w, rd: !w, cmd: c, wdata: d};
    @(negedge ref_clk);
    // Idle fields change so a stale decode is never trusted.
    req = '{wr: 1'b0, rd: 1'b0, cmd: ~c, wdata: ~d};
    q = rvalid ? rdata : 8'hxx;
  endtask
endmodule

// *** dv/cmr_cfg_regs_bench.sv ***
// Self-checking bench for the configuration bank.
// Assumes the host model drives all register traffic.
`timescale 1ns/1ps
module cmr_cfg_regs_bench;
  import cmr_pkg::*;
  typedef struct {logic [7:0] c, d; logic ph; logic [7:0] r;
    logic [12:0] v;} cmr_row_t;
  logic ref_clk, arst_n, ctrl_enable, power_good_pin, output_ok;
  logic phase_mode_bit, rvalid, cmd_hit, discharge_on, follower_fault;
  logic power_good_out;
  logic [6:0] addr_strap;
  logic [7:0] rdata, q;
  logic [9:0] ramp_uv10;
  logic [12:0] vmin, vmax;
  cmr_req_t req;
  cmr_ctrl_t ctrl;
  int fail_count, checks;
  logic [7:0] dflt [4] = '{8'h09, 8'h40, 8'h05, 8'hB0};
  cmr_row_t rows [10] = '{
    '{8'hD0, 8'h1F, 1'b1, 8'h1F, 13'h02A8}, '{8'hD0, 8'h00, 1'b0, 8'h00,
    13'h0038}, '{8'hD0, 8'h08, 1'b0, 8'h08, 13'h0055}, '{8'hD0, 8'h09,
    1'b1, 8'h09, 13'h0082}, '{8'hD1, 8'h03, 1'b0, 8'h03, 13'h1500},
    '{8'hD1, 8'h01, 1'b0, 8'h01, 13'h0540}, '{8'hD2, 8'hFF, 1'b0, 8'h07,
    13'h03E8}, '{8'hD2, 8'h02, 1'b0, 8'h02, 13'h0258}, '{8'hD3, 8'h85,
    1'b0, 8'h85, 13'h0005}, '{8'hD3, 8'h05, 1'b0, 8'h05, 13'h002A}};
  cmr_cfg_regs #(.CYC_PER_MS(10)) dut_u (.ref_clk, .arst_n, .req,
    .phase_mode_bit, .addr_strap, .ctrl_enable, .power_good_pin, .output_ok,
    .rdata, .rvalid, .cmd_hit, .ctrl, .ramp_uv10, .vout_min_mv(vmin),
    .vout_max_mv(vmax), .discharge_on, .follower_fault, .power_good_out);
  cmr_host_model host_u (.ref_clk, .req, .rdata, .rvalid);
  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [12:0] g, e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [12:0] dec(input logic [1:0] s);
    case (s)
      2'h0: dec = 13'(ramp_uv10);
      2'h1: dec = vmax;
      2'h2: dec = 13'(ctrl.fsw_khz);
      default: dec = 13'(ctrl.bus_address);
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100_000;
    fail_count++;
    report_and_stop;
  end
  initial begin
    {arst_n, ctrl_enable, output_ok, phase_mode_bit} = 4'h0;
    power_good_pin = 1;
    addr_strap = 7'h2A;
    repeat (4) @(negedge ref_clk);
    arst_n = 1;
    foreach (dflt[i]) begin
      host_u.xfer(0, 8'hD0 + 8'(i), 8'h00, q);
      chk(q, dflt[i]);
    end
    chk(ctrl.bus_address, 13'h0030);
    chk(discharge_on, 13'h0001);
    $display("reset values done");
    foreach (rows[i]) begin
      phase_mode_bit = rows[i].ph;
      host_u.xfer(1, rows[i].c, rows[i].d, q);
      chk(dec(rows[i].c[1:0]), rows[i].v);
      host_u.xfer(0, rows[i].c, 8'h00, q);
      chk(q, rows[i].r);
    end
    chk(discharge_on, 13'h0000);
    chk(ctrl.light_load_mode_sel, 13'h0000);
    chk(ctrl.follower_fault_en, 13'h0001);
    chk(ctrl.cff_50pf, 13'h0000);
    host_u.xfer(1, 8'hD1, 8'h02, q);
    chk(vmin, 13'h02BC);
    chk(vmax, 13'h0A80);
    host_u.xfer(1, 8'hD1, 8'h03, q);
    chk(vmin, 13'h0514);
    $display("table done");
    host_u.xfer(1, 8'hD4, 8'h55, q);
    host_u.xfer(0, 8'hD4, 8'h00, q);
    chk(q, 13'h0000);
    host_u.xfer(1, 8'hD1, 8'h44, q);
    chk(vmin, 13'h0190);
    {ctrl_enable, output_ok, power_good_pin} = 3'h6;
    repeat (12) @(negedge ref_clk);
    chk(power_good_out, 13'h0000);
    chk(discharge_on, 13'h0000);
    chk(follower_fault, 13'h0001);
    repeat (12) @(negedge ref_clk);
    chk(power_good_out, 13'h0000);
    repeat (3) @(negedge ref_clk);
    chk(power_good_out, 13'h0001);
    host_u.xfer(1, 8'hD1, 8'h7C, q);
    output_ok = 0;
    @(negedge ref_clk);
    chk(power_good_out, 13'h0000);
    output_ok = 1;
    repeat (2) @(negedge ref_clk);
    chk(power_good_out, 13'h0001);
    host_u.xfer(1, 8'hD0, 8'h08, q);
    chk(follower_fault, 13'h0000);
    $display("pins done");
    arst_n = 0;
    repeat (2) @(negedge ref_clk);
    chk(power_good_out, 13'h0000);
    arst_n = 1;
    host_u.xfer(0, 8'hD3, 8'h00, q);
    chk(q, 13'h00B0);
    $display("second reset done");
    report_and_stop;
  end
endmodule
